// *** dv/dtp_emu_model.sv ***
`timescale 1ns/100ps
module dtp_emu_model (
  input  wire logic                ser_clk_in,   // system clock
  input  wire logic                ser_rx_in,    // device serial output
  input  wire logic                trace_clk_in, // trace clock
  input  wire dtp_pkg::dtp_trace_t trace_in,     // trace bus
  output logic                     ser_clk_out,  // serial clock to device
  output logic                     ser_tx_out    // serial data to device
);
  import dtp_pkg::*;
  dtp_trace_t trace_q[$];
  dtp_trace_t trace_prev;
  logic       tclk_prev;
  int         trace_bad;

  initial begin
    ser_clk_out = 1'b0;
    ser_tx_out  = 1'b1;
    tclk_prev   = 1'b0;
    trace_prev  = '0;
    trace_bad   = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // nine system clocks a bit keeps well under the rate limit
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      ser_tx_out <= tx[i];
      repeat (4) @(posedge ser_clk_in);
      ser_clk_out <= 1'b1;
      repeat (4) @(posedge ser_clk_in);
      ser_clk_out <= 1'b0;
      // device output moves just after its synchronised rise; read it then
      @(posedge ser_clk_in);
      rx[i] = ser_rx_in;
    end
    ser_tx_out <= ~tx[0]; // released line must not look valid
  endtask

  // one-clock spike, too short to count as an edge
  task automatic glitch();
    ser_clk_out <= 1'b1;
    @(posedge ser_clk_in);
    ser_clk_out <= 1'b0;
    repeat (4) @(posedge ser_clk_in);
  endtask

  // old samples are worthless after a quiet spell
  task automatic resync();
    trace_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ser_clk_in) begin
    if (trace_clk_in === 1'b1 && tclk_prev === 1'b0) begin
      trace_q.push_back(trace_in);
      if (trace_in !== trace_prev) begin
        trace_bad <= trace_bad + 1;
      end
    end
    tclk_prev  <= trace_clk_in;
    trace_prev <= trace_in;
  end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb;
  import dtp_pkg::*;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, opnd = 32'h0, r;
  logic        ack, ser_clk, ser_in, ser_out, brk = 1'b0, tclk;
  logic        done = 1'b0, wdd = 1'b0, branch = 1'b0, halt, irq, stall;
  logic [3:0]  cstat = 4'h0, hwbrk = 4'h0;
  logic [1:0]  size = 2'h0;
  logic [15:0] rx;
  dtp_trace_t  trace, saved;
  logic        saved_clk;
  int          errors = 0, checks = 0, irq_n = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;

  dtp_debug_port u_dtp_debug_port (.SYS_CLK_IN(clk), .RST_IN(rst),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .SER_CLK_IN(ser_clk), .SER_IN(ser_in), .SER_OUT(ser_out),
    .BREAK_IN(brk), .TRACE_CLK_OUT(tclk), .TRACE_OUT(trace),
    .CORE_STATUS_IN(cstat), .CORE_DONE_IN(done), .CORE_WDD_IN(wdd),
    .CORE_BRANCH_IN(branch), .CORE_OPERAND_IN(opnd), .CORE_SIZE_IN(size),
    .HW_BRK_STAT_IN(hwbrk), .CORE_HALT_OUT(halt), .CORE_IRQ_OUT(irq),
    .CORE_STALL_OUT(stall));
  dtp_emu_model u_dtp_emu_model (.ser_clk_in(clk), .ser_rx_in(ser_out),
    .trace_clk_in(tclk), .trace_in(trace), .ser_clk_out(ser_clk),
    .ser_tx_out(ser_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic push(input logic br, input logic [31:0] d,
                      input logic [1:0] s);
    @(posedge clk);
    wdd <= ~br;
    branch <= br;
    opnd <= d;
    size <= s;
    @(posedge clk);
    wdd <= 1'b0;
    branch <= 1'b0;
  endtask

  // first marker in the sampled trace, then its nibbles
  task automatic burst(input logic [31:0] d, input logic [1:0] s);
    int m;
    m = 0;
    while (m < u_dtp_emu_model.trace_q.size() - 1 &&
           u_dtp_emu_model.trace_q[m].status[3:2] !== PST_MARK) m++;
    `CHK("marker", {PST_MARK, s}, u_dtp_emu_model.trace_q[m].status)
    for (int n = 0; n < 2 * (s + 1); n++)
      `CHK("nibble", d[4*n+:4], u_dtp_emu_model.trace_q[m+1+n].data)
  endtask

  initial begin
    tick(20000);
    errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    rst <= 1'b0;
    tick(10);
    `CHK("idle trace", 8'h00, trace)
    `CHK("idle samples", 0, u_dtp_emu_model.trace_q.size())
    wb(1'b0, ADR_STAT, 32'h0, r);
    `CHK("stat reset", 32'h0, r)
    wb(1'b0, 8'h10, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    cstat <= PST_RST_C;
    tick(10);
    cstat <= 4'h1;
    hwbrk <= 4'h5;
    tick(10);
    `CHK("trace runs", 1'b1, u_dtp_emu_model.trace_q.size() > 0)
    `CHK("brk status", 8'h15, trace)
    u_dtp_emu_model.resync();
    push(1'b0, 32'h89abcdef, 2'h1);
    tick(30);
    burst(32'h89abcdef, 2'h1);
    wb(1'b1, ADR_CTRL, 32'h4, r);
    u_dtp_emu_model.resync();
    push(1'b1, 32'h0000005a, 2'h0);
    tick(30);
    burst(32'h0000005a, 2'h0);
    wb(1'b1, ADR_CTRL, 32'h0, r);
    brk <= 1'b1;
    tick(6);
    `CHK("no early halt", 1'b0, halt)
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(10);
    `CHK("halted", 1'b1, halt)
    `CHK("halt status", PST_HALTED, trace.status)
    brk <= 1'b0;
    push(1'b0, 32'h11111111, 2'h3);
    push(1'b0, 32'h22222222, 2'h3);
    tick(4);
    `CHK("stall", 1'b1, stall)
    wb(1'b1, ADR_TXD, 32'h0000beef, r);
    u_dtp_emu_model.frame(CMD_GO, rx);
    `CHK("first frame", 16'h0000, rx)
    tick(10);
    `CHK("resumed", 1'b0, halt)
    tick(60);
    `CHK("stall gone", 1'b0, stall)
    u_dtp_emu_model.glitch();
    u_dtp_emu_model.frame(16'h5a3c, rx);
    `CHK("tx word", 16'hbeef, rx)
    tick(10);
    wb(1'b0, ADR_STAT, 32'h0, r);
    `CHK("stat frame", 32'h6, r)
    wb(1'b0, ADR_RXD, 32'h0, r);
    `CHK("rx word", 32'h00005a3c, r)
    u_dtp_emu_model.frame(CMD_HALT, rx);
    `CHK("tx again", 16'hbeef, rx)
    tick(10);
    `CHK("cmd no early halt", 1'b0, halt)
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(4);
    `CHK("cmd halted", 1'b1, halt)
    u_dtp_emu_model.frame(CMD_GO, rx);
    tick(10);
    `CHK("cmd resumed", 1'b0, halt)
    wb(1'b1, ADR_CTRL, 32'h3, r);
    tick(4);
    saved = trace;
    saved_clk = tclk;
    cstat <= 4'h2;
    hwbrk <= 4'ha;
    brk <= 1'b1;
    tick(20);
    `CHK("frozen trace", saved, trace)
    `CHK("frozen clock", saved_clk, tclk)
    `CHK("irq pulses", 1, irq_n)
    `CHK("no halt", 1'b0, halt)
    brk <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h0, r);
    u_dtp_emu_model.resync();
    tick(20);
    `CHK("trace back", 1'b1, u_dtp_emu_model.trace_q.size() > 0)
    `CHK("trace status", 4'h2, trace.status)
    `CHK("clock centred", 0, u_dtp_emu_model.trace_bad)
    final_report();
  end
endmodule

// *** rtl/dtp_debug_port.sv ***
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module dtp_debug_port (
  input  wire logic              SYS_CLK_IN,      // 40 MHz
  input  wire logic              RST_IN,          // async, high
  input  wire logic              WB_CYC_IN,       // bus cycle
  input  wire logic              WB_STB_IN,       // bus strobe
  input  wire logic              WB_WE_IN,        // write
  input  wire logic [7:0]        WB_ADR_IN,       // byte address
  input  wire logic [3:0]        WB_SEL_IN,       // byte lanes
  input  wire logic [31:0]       WB_DAT_IN,       // write data
  output logic      [31:0]       WB_DAT_OUT,      // read data
  output logic                   WB_ACK_OUT,      // acknowledge
  input  wire logic              SER_CLK_IN,      // debug_serial_clock
  input  wire logic              SER_IN,          // serial data in
  output logic                   SER_OUT,         // debug_serial_out
  input  wire logic              BREAK_IN,        // manual_break_request
  output logic                   TRACE_CLK_OUT,   // trace_clock
  output dtp_pkg::dtp_trace_t    TRACE_OUT,       // status, data
  input  wire logic [3:0]        CORE_STATUS_IN,  // pipeline status
  input  wire logic              CORE_DONE_IN,    // instruction completes
  input  wire logic              CORE_WDD_IN,     // write-debug-data pulse
  input  wire logic              CORE_BRANCH_IN,  // branch target pulse
  input  wire logic [31:0]       CORE_OPERAND_IN, // operand or address
  input  wire logic [1:0]        CORE_SIZE_IN,    // bytes minus one
  input  wire logic [3:0]        HW_BRK_STAT_IN,  // breakpoint status
  output logic                   CORE_HALT_OUT,   // halted
  output logic                   CORE_IRQ_OUT,    // debug interrupt pulse
  output logic                   CORE_STALL_OUT   // capture full
);
  import dtp_pkg::*;

  //////////////////////////////////////////////////////////////////////
  dtp_ctrl_t         ctrl;
  logic [15:0]       rx_word;
  logic [15:0]       tx_word;
  logic              rx_valid;
  logic              frame_done;
  logic              bus_req;
  logic              rd_rx;
  logic              trace_run;

  assign bus_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign rd_rx   = bus_req && !WB_WE_IN && WB_ADR_IN == ADR_RXD;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end else begin
      WB_ACK_OUT <= bus_req;
      WB_DAT_OUT <= 32'h0;
      if (bus_req && !WB_WE_IN) begin
        unique case (WB_ADR_IN)
          ADR_CTRL: WB_DAT_OUT <= {29'h0, ctrl};
          ADR_STAT: WB_DAT_OUT <= {28'h0, CORE_STALL_OUT, rx_valid,
                                   trace_run, CORE_HALT_OUT};
          ADR_RXD:  WB_DAT_OUT <= {16'h0, rx_word};
          ADR_TXD:  WB_DAT_OUT <= {16'h0, tx_word};
          default:  WB_DAT_OUT <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl    <= '0;
      tx_word <= 16'h0;
    end else if (bus_req && WB_WE_IN) begin
      if (WB_ADR_IN == ADR_CTRL && WB_SEL_IN[0])
        ctrl <= WB_DAT_IN[2:0];
      if (WB_ADR_IN == ADR_TXD && WB_SEL_IN[0])
        tx_word[7:0] <= WB_DAT_IN[7:0];
      if (WB_ADR_IN == ADR_TXD && WB_SEL_IN[1])
        tx_word[15:8] <= WB_DAT_IN[15:8];
    end
  end

  // a frame landing in the read cycle keeps the flag set
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN)
      rx_valid <= 1'b0;
    else if (frame_done)
      rx_valid <= 1'b1;
    else if (rd_rx)
      rx_valid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // serial channel; works whether or not the core is halted
  logic [2:0]  sclk_sync;
  logic [1:0]  sin_sync;
  logic        sclk_lvl;
  logic        ser_edge;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [4:0]  bit_cnt;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sclk_sync <= 3'h0;
      sin_sync  <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], SER_CLK_IN};
      sin_sync  <= {sin_sync[0], SER_IN};
    end
  end

  // a level counts only when two stages past the first agree
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN)
      sclk_lvl <= 1'b0;
    else if (sclk_sync[2] == sclk_sync[1])
      sclk_lvl <= sclk_sync[2];
  end
  assign ser_edge = !sclk_lvl && sclk_sync[2] && sclk_sync[1];
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_shift   <= 16'h0;
      tx_shift   <= 16'h0;
      bit_cnt    <= 5'h0;
      SER_OUT    <= 1'b0;
      rx_word    <= 16'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (ser_edge) begin
        rx_shift <= {rx_shift[14:0], sin_sync[1]};
        SER_OUT  <= tx_shift[15];
        tx_shift <= {tx_shift[14:0], 1'b0};
        bit_cnt  <= bit_cnt + 5'h1;
        if (bit_cnt == 5'(SER_BITS - 1)) begin
          bit_cnt    <= 5'h0;
          rx_word    <= {rx_shift[14:0], sin_sync[1]};
          tx_shift   <= tx_word;
          frame_done <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // manual break and halt
  logic [1:0] brk_sync;
  logic       brk_last;
  logic       brk_edge;
  logic       halt_pend;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      brk_sync <= 2'h0;
      brk_last <= 1'b0;
    end else begin
      brk_sync <= {brk_sync[0], BREAK_IN};
      brk_last <= brk_sync[1];
    end
  end
  assign brk_edge = brk_sync[1] && !brk_last;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      halt_pend     <= 1'b0;
      CORE_HALT_OUT <= 1'b0;
      CORE_IRQ_OUT  <= 1'b0;
    end else begin
      CORE_IRQ_OUT <= brk_edge && ctrl.redirect;
      if (brk_edge && !ctrl.redirect && !CORE_HALT_OUT)
        halt_pend <= 1'b1;
      if (frame_done && rx_word == CMD_HALT)
        halt_pend <= 1'b1;
      if (halt_pend && CORE_DONE_IN) begin
        halt_pend     <= 1'b0;
        CORE_HALT_OUT <= 1'b1;
      end
      if (frame_done && rx_word == CMD_GO)
        CORE_HALT_OUT <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // two-entry capture queue
  dtp_entry_t fifo [FIFO_DEPTH];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] fifo_cnt;
  logic       push;
  logic       pop;
  logic [1:0] next_cnt;

  assign push = (CORE_WDD_IN || (CORE_BRANCH_IN && ctrl.capture))
                && fifo_cnt != 2'(FIFO_DEPTH);
  assign next_cnt = fifo_cnt + 2'(push) - 2'(pop);

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_ptr         <= 1'b0;
      rd_ptr         <= 1'b0;
      fifo_cnt       <= 2'h0;
      CORE_STALL_OUT <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= !wr_ptr;
      if (pop)
        rd_ptr <= !rd_ptr;
      fifo_cnt       <= next_cnt;
      CORE_STALL_OUT <= next_cnt == 2'(FIFO_DEPTH);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (push)
      fifo[wr_ptr] <= '{data: CORE_OPERAND_IN, size: CORE_SIZE_IN};
  end

  //////////////////////////////////////////////////////////////////////
  // trace port: two clocks a trace cycle so its clock rises mid-window
  logic       phase;
  logic       te;
  dtp_tr_t    tr_state;
  logic [2:0] nib;
  dtp_entry_t head;

  assign head = fifo[rd_ptr];
  assign te   = trace_run && !ctrl.quiesce && !phase;
  assign pop  = te && !CORE_HALT_OUT && tr_state == TR_DATA
                && nib == {head.size, 1'b1};

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      phase     <= 1'b0;
      trace_run <= 1'b0;
    end else begin
      phase <= !phase;
      if (CORE_STATUS_IN == PST_RST_C || CORE_STATUS_IN == PST_RST_D
          || CORE_STATUS_IN == PST_HALTED || CORE_HALT_OUT)
        trace_run <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN)
      TRACE_CLK_OUT <= 1'b0;
    else if (trace_run && !ctrl.quiesce)
      TRACE_CLK_OUT <= phase;
  end

  // quiesce only stops the trace; break and halt logic run on
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TRACE_OUT <= '0;
      tr_state  <= TR_IDLE;
      nib       <= 3'h0;
    end else if (te) begin
      TRACE_OUT.status <= CORE_STATUS_IN;
      TRACE_OUT.data   <= HW_BRK_STAT_IN;
      if (CORE_HALT_OUT) begin
        TRACE_OUT.status <= PST_HALTED;
      end else begin
        unique case (tr_state)
          TR_IDLE: begin
            if (fifo_cnt != 2'h0) begin
              TRACE_OUT.status <= {PST_MARK, head.size};
              nib      <= 3'h0;
              tr_state <= TR_DATA;
            end
          end
          TR_DATA: begin
            TRACE_OUT.data <= head.data[{nib, 2'b00} +: 4];
            nib            <= nib + 3'h1;
            if (pop)
              tr_state <= TR_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking dtp_cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  property p_ser_shift;
    ser_edge |=> SER_OUT == $past(tx_shift[15]);
  endproperty
  a_ser_shift: assert property (p_ser_shift)
    else $error("serial out did not shift on serial edge");
  property p_ser_still;
    !ser_edge |=> $stable(SER_OUT);
  endproperty
  a_ser_still: assert property (p_ser_still)
    else $error("serial out moved without serial edge");
  property p_sclk_valid;
    !$stable(sclk_lvl) |-> $past(sclk_sync[2]) == $past(sclk_sync[1]);
  endproperty
  a_sclk_valid: assert property (p_sclk_valid)
    else $error("serial clock accepted without two equal samples");
  property p_break_halt;
    halt_pend && CORE_DONE_IN && !(frame_done && rx_word == CMD_GO)
    |=> CORE_HALT_OUT;
  endproperty
  a_break_halt: assert property (p_break_halt)
    else $error("pending halt not taken at instruction end");
  property p_break_irq;
    brk_edge && ctrl.redirect |=> CORE_IRQ_OUT ##1 !CORE_IRQ_OUT;
  endproperty
  a_break_irq: assert property (p_break_irq)
    else $error("redirected break gave no single interrupt pulse");
  property p_halt_status;
    te && CORE_HALT_OUT |=> TRACE_OUT.status == PST_HALTED;
  endproperty
  a_halt_status: assert property (p_halt_status)
    else $error("halted core without status 0xf");
  property p_quiesce;
    ctrl.quiesce |=> $stable(TRACE_CLK_OUT) && $stable(TRACE_OUT);
  endproperty
  a_quiesce: assert property (p_quiesce)
    else $error("trace moved during quiesce");
  property p_idle;
    !trace_run |-> TRACE_OUT == '0 && !TRACE_CLK_OUT;
  endproperty
  a_idle: assert property (p_idle)
    else $error("trace active before start");
  property p_tclk_mid;
    te ##1 !ctrl.quiesce |-> !TRACE_CLK_OUT ##1 TRACE_CLK_OUT;
  endproperty
  a_tclk_mid: assert property (p_tclk_mid)
    else $error("trace clock not centred in window");
  property p_mark_data;
    te && !CORE_HALT_OUT && tr_state == TR_IDLE && fifo_cnt != 2'h0
    |=> TRACE_OUT.status[3:2] == PST_MARK && tr_state == TR_DATA;
  endproperty
  a_mark_data: assert property (p_mark_data)
    else $error("marker missing before data");
  property p_stall;
    CORE_STALL_OUT == (fifo_cnt == 2'(FIFO_DEPTH));
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall does not match full queue");

  c_halt:  cover property (@(posedge SYS_CLK_IN) $rose(CORE_HALT_OUT));
  c_irq:   cover property (@(posedge SYS_CLK_IN) CORE_IRQ_OUT);
  c_frame: cover property (@(posedge SYS_CLK_IN) frame_done);
  c_pop:   cover property (@(posedge SYS_CLK_IN) pop);
endmodule

// *** rtl/dtp_pkg.sv ***
package dtp_pkg;
  // trace status codes
  localparam logic [3:0] PST_ZERO   = 4'h0;
  localparam logic [3:0] PST_RST_C  = 4'hc;
  localparam logic [3:0] PST_RST_D  = 4'hd;
  localparam logic [3:0] PST_HALTED = 4'hf;
  localparam logic [1:0] PST_MARK   = 2'b10;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_RXD  = 8'h08;
  localparam logic [7:0] ADR_TXD  = 8'h0c;
  // serial frame, commands and capture queue depth
  localparam int          SER_BITS = 16;
  localparam logic [15:0] CMD_HALT = 16'h0a5a;
  localparam logic [15:0] CMD_GO   = 16'h0c3c;
  localparam int          FIFO_DEPTH = 2;

  typedef struct packed {
    logic        capture;
    logic        quiesce;
    logic        redirect;
  } dtp_ctrl_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  size;   // bytes minus one
  } dtp_entry_t;

  typedef struct packed {
    logic [3:0]  status;
    logic [3:0]  data;
  } dtp_trace_t;

  typedef enum logic {
    TR_IDLE = 1'b0,
    TR_DATA = 1'b1
  } dtp_tr_t;
endpackage
